// ---- chg_host_model.sv ----
// Serial bus master model standing in for the host processor
`timescale 1ns/1ps
module chg_host_model #(
  parameter realtime KICK_GAP_NS = 20000.0
) (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_drv,
  output logic      sda_drv,
  output logic      rsp_v,
  output logic [8:0] rsp_d
);
  import chg_pkg::*;
  realtime last_kick;

  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    rsp_v = 1'b0;
    rsp_d = 9'h000;
    last_kick = -1.0e9;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Data only moves while the clock line is low
  task automatic put_bit(input logic b, output logic r);
    sda_drv = b;
    tick(3);
    scl_drv = 1'b1;
    tick(2);
    r = sda_line;
    tick(2);
    scl_drv = 1'b0;
    tick(1);
  endtask

  task automatic start();
    sda_drv = 1'b1;
    tick(3);
    scl_drv = 1'b1;
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl_drv = 1'b0;
    tick(1);
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    tick(3);
    scl_drv = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask

  // Result pairs the ninth-bit level with the byte seen on the line
  task automatic byte_io(input logic [7:0] d, input logic ack_in);
    logic [7:0] q;
    logic       a;
    for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
    put_bit(ack_in, a);
    rsp_d = {a, q};
    rsp_v = 1'b1;
    tick(1);
    rsp_v = 1'b0;
  endtask

  task automatic space_kick();
    while ($realtime - last_kick < KICK_GAP_NS) tick(1);
    last_kick = $realtime;
  endtask
endmodule // chg_host_model

// ---- chg_pkg.sv ----
// Shared constants and types for the charger configuration register bank
package chg_pkg;

  // Bus address and register index map
  localparam logic [6:0] DEV_ADDR_DEF = 7'h6b;
  localparam int         NUM_RW       = 8;
  localparam logic [7:0] IDX_IN_SRC   = 8'h00;
  localparam logic [7:0] IDX_PWR_CFG  = 8'h01;
  localparam logic [7:0] IDX_CHG_CUR  = 8'h02;
  localparam logic [7:0] IDX_PRECHG   = 8'h03;
  localparam logic [7:0] IDX_STAT0    = 8'h08;
  localparam logic [7:0] IDX_STAT1    = 8'h09;
  localparam logic [7:0] IDX_LAST     = 8'h0a;
  localparam logic [7:0] IDX_AUTO_END = 8'h08;

  // Reset values
  localparam logic [4:0] IN_SRC_RST_HI = 5'h06;
  localparam logic [7:0] PWR_CFG_RST   = 8'h1b;
  localparam logic [7:0] CHG_CUR_RST   = 8'h60;
  localparam logic [7:0] PRECHG_RST    = 8'h11;
  localparam logic [7:0] OTHER_RST     = 8'h00;

  // Input current cap codes chosen by the pins at reset
  localparam logic [2:0] CAP_3A    = 3'h7;
  localparam logic [2:0] CAP_100MA = 3'h0;
  localparam logic [2:0] CAP_500MA = 3'h2;

  // Bits that can store a one; the others never do
  localparam logic [7:0] PWR_WR_MASK = 8'h3f;
  localparam logic [7:0] CUR_WR_MASK = 8'h7f;

  // Serial bit counts
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BITS  = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_WRITE, ST_READ
  } chg_state_t;

  typedef struct packed {
    logic       input_hiz_enable;
    logic [3:0] input_voltage_floor;
    logic [2:0] input_current_cap;
  } chg_in_src_t;

  typedef struct packed {
    logic       reg_reset;
    logic       wdt_kick;
    logic       boost_output_enable;
    logic       charge_enable_cfg;
    logic [2:0] system_voltage_floor;
    logic       boost_current_cap;
  } chg_pwr_t;

  typedef struct packed {
    logic       reserved;
    logic [4:0] fast_charge_current;
    logic       boost_cold_threshold;
    logic       reduced_charge_force;
  } chg_cur_t;

  // Settings handed to the analog side
  typedef struct packed {
    logic       input_hiz_enable;
    logic [3:0] input_voltage_floor;
    logic [2:0] input_current_cap;
    logic       boost_output_enable;
    logic       charge_enable;
    logic [2:0] system_voltage_floor;
    logic       boost_current_cap;
    logic [4:0] fast_charge_current;
    logic       boost_cold_threshold;
    logic       reduced_charge_force;
  } chg_cfg_t;

  // Read-only status bytes at indices 8, 9 and 10
  typedef struct packed {
    logic [7:0] stat_0a;
    logic [7:0] stat_09;
    logic [7:0] stat_08;
  } chg_stat_t;

endpackage

// ---- chg_regbank.sv ----
// Serial-bus slave and configuration register bank of the charger
`timescale 1ns/1ps

// Contract
// - Answer as serial slave at 7-bit address 0x6B only.
// - Indices 0x00-0x07 read/write; 0x08-0x0A read-only.
// - Input source control resets upper five bits to 00110.
// - Bit 7 of input source control enables input high-impedance; resets 0.
// - Bits 6:3 input voltage floor, 80 mV steps from 3.88 V; reset 0110.
// - Reset cap: 3 A if select low, else 100 mA or 500 mA by OTG pin.
// - Power-on config resets to 0x1B; bit 0 picks 1 A or 1.5 A boost.
// - Writing bit 7 restores all defaults but keeps host mode.
// - Bit 5 enables boost, resets 0, overrides charge enable.
// - Bit 4 enables charging, resets 1.
// - Bits 3:1 system voltage floor from 3.0 V, reset 101.
// - Charge current control resets 0x60; bit 7 reserved, rest read/write.
// - Any register write puts the device into host mode.
// - Undefined index gets NACK and a return to idle.
// - Multi-byte reads and writes auto-increment over 0x00-0x08.
module chg_regbank #(
  parameter logic [6:0] DEV_ADDR = chg_pkg::DEV_ADDR_DEF
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  input  wire logic              source_select_pin,
  input  wire logic              otg_pin,
  input  wire logic [2:0]        current_cap_pin,
  input  wire chg_pkg::chg_stat_t status_i,
  output chg_pkg::chg_cfg_t      cfg,
  output logic                   host_mode,
  output logic                   wdt_kick
);
  import chg_pkg::*;

  if (DEV_ADDR == 7'h00) begin : g_chk
    $error("Slave address zero is the general call address");
  end

  logic                     scl_q_ff;
  logic                     sda_q_ff;
  chg_state_t               state_ff;
  logic [3:0]               bit_cnt_ff;
  logic [7:0]               shift_ff;
  logic [7:0]               tx_ff;
  logic [7:0]               idx_ff;
  logic                     sda_oe_n_ff;
  logic                     pin_lo_ff;
  logic                     scl_oe_n_ff;
  logic                     host_mode_ff;
  logic                     wdt_kick_ff;
  logic [NUM_RW-1:0][7:0]   regs_ff;
  chg_cfg_t                 cfg_ff;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_c;
  logic                     stop_c;
  logic                     byte_end;
  logic                     ack_end;
  logic                     wr_byte;
  logic                     soft_rst;
  logic [2:0]               cap_def;
  logic [7:0]               nxt_idx;
  chg_pwr_t                 wr_pwr;
  chg_in_src_t              src_v;
  chg_pwr_t                 pwr_v;
  chg_cur_t                 cur_v;

  function automatic logic [7:0] rd_mux(input logic [7:0] i,
      input logic [NUM_RW-1:0][7:0] r, input chg_stat_t s);
    logic [7:0] v;
    v = 8'h00;
    if (i < 8'(NUM_RW))  v = r[i[2:0]];
    else if (i == IDX_STAT0) v = s.stat_08;
    else if (i == IDX_STAT1) v = s.stat_09;
    else v = s.stat_0a;
    return v;
  endfunction

  function automatic logic [7:0] reg_default(input logic [7:0] i,
      input logic [2:0] cap);
    logic [7:0] v;
    v = OTHER_RST;
    if (i == IDX_IN_SRC) v = {IN_SRC_RST_HI, cap};
    else if (i == IDX_PWR_CFG) v = PWR_CFG_RST;
    else if (i == IDX_CHG_CUR) v = CHG_CUR_RST;
    else if (i == IDX_PRECHG) v = PRECHG_RST;
    return v;
  endfunction

  // Command bits and the reserved bit always read back as zero
  function automatic logic [7:0] wr_value(input logic [7:0] i,
      input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (i == IDX_PWR_CFG) v = d & PWR_WR_MASK;
    else if (i == IDX_CHG_CUR) v = d & CUR_WR_MASK;
    return v;
  endfunction

  // Inputs are synchronous, so edges come from one stage of history
  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign start_c  = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_c   = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  assign byte_end = scl_fall && (bit_cnt_ff == BYTE_BITS);
  assign ack_end  = scl_fall && (bit_cnt_ff == ACK_BITS);
  assign wr_byte  = byte_end && (state_ff == ST_WRITE);
  assign wr_pwr   = chg_pwr_t'(shift_ff);
  assign src_v    = chg_in_src_t'(regs_ff[IDX_IN_SRC[2:0]]);
  assign pwr_v    = chg_pwr_t'(regs_ff[IDX_PWR_CFG[2:0]]);
  assign cur_v    = chg_cur_t'(regs_ff[IDX_CHG_CUR[2:0]]);
  assign soft_rst = wr_byte && (idx_ff == IDX_PWR_CFG) && wr_pwr.reg_reset;
  assign cap_def  = source_select_pin ? (otg_pin ? CAP_500MA : CAP_100MA)
                                      : CAP_3A;
  // Auto-increment stops at the last multi-access index
  assign nxt_idx  = (idx_ff < IDX_AUTO_END) ? idx_ff + 8'h01 : idx_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // Clock line is never stretched; data line only ever pulled low
  always_ff @(posedge mclk) begin
    pin_lo_ff   <= 1'b0;
    scl_oe_n_ff <= 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      tx_ff       <= 8'h00;
      idx_ff      <= 8'h00;
      sda_oe_n_ff <= 1'b1;
    end else if (start_c) begin
      state_ff    <= ST_ADDR;
      bit_cnt_ff  <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end else if (stop_c) begin
      state_ff    <= ST_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else if (state_ff != ST_IDLE && scl_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (bit_cnt_ff < BYTE_BITS) begin
        shift_ff <= {shift_ff[6:0], sda_i};
      end else if (state_ff == ST_READ && sda_i) begin
        // Master NACK ends the read burst
        state_ff <= ST_IDLE;
      end
    end else if (state_ff != ST_IDLE && byte_end) begin
      unique case (state_ff)
        ST_ADDR: begin
          if (shift_ff[7:1] == DEV_ADDR) sda_oe_n_ff <= 1'b0;
          else state_ff <= ST_IDLE;
        end
        ST_INDEX: begin
          if (shift_ff <= IDX_LAST) begin
            sda_oe_n_ff <= 1'b0;
            idx_ff      <= shift_ff;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        ST_WRITE: sda_oe_n_ff <= 1'b0;
        ST_READ:  sda_oe_n_ff <= 1'b1;
        ST_IDLE:  sda_oe_n_ff <= 1'b1;
      endcase
    end else if (state_ff != ST_IDLE && ack_end) begin
      bit_cnt_ff  <= 4'h0;
      sda_oe_n_ff <= 1'b1;
      unique case (state_ff)
        ST_ADDR: begin
          if (shift_ff[0]) begin
            state_ff    <= ST_READ;
            sda_oe_n_ff <= rd_mux(idx_ff, regs_ff, status_i) [7];
            tx_ff       <= rd_mux(idx_ff, regs_ff, status_i) << 1;
          end else begin
            state_ff <= ST_INDEX;
          end
        end
        ST_INDEX: state_ff <= ST_WRITE;
        // Next index after each data byte
        ST_WRITE: idx_ff <= nxt_idx;
        ST_READ: begin
          idx_ff      <= nxt_idx;
          sda_oe_n_ff <= rd_mux(nxt_idx, regs_ff, status_i) [7];
          tx_ff       <= rd_mux(nxt_idx, regs_ff, status_i) << 1;
        end
        ST_IDLE: sda_oe_n_ff <= 1'b1;
      endcase
    end else if (state_ff == ST_READ && scl_fall) begin
      // Released line reads as one
      sda_oe_n_ff <= tx_ff[7];
      tx_ff       <= tx_ff << 1;
    end
  end

  // Storage exists only for writable indices
  for (genvar g = 0; g < NUM_RW; g++) begin : g_reg
    always_ff @(posedge mclk) begin
      if (!rst_n || soft_rst) begin
        regs_ff[g] <= reg_default(8'(g), cap_def);
      end else if (wr_byte && idx_ff == 8'(g)) begin
        regs_ff[g] <= wr_value(8'(g), shift_ff);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_mode_ff <= 1'b0;
    end else if (wr_byte) begin
      host_mode_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) wdt_kick_ff <= 1'b0;
    else wdt_kick_ff <= wr_byte && idx_ff == IDX_PWR_CFG && wr_pwr.wdt_kick;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff.input_hiz_enable     <= src_v.input_hiz_enable;
      cfg_ff.input_voltage_floor  <= src_v.input_voltage_floor;
      // Lower of register and pin cap
      cfg_ff.input_current_cap    <=
          (src_v.input_current_cap < current_cap_pin)
          ? src_v.input_current_cap : current_cap_pin;
      cfg_ff.boost_output_enable  <= pwr_v.boost_output_enable;
      cfg_ff.charge_enable        <= pwr_v.charge_enable_cfg &
                                     ~pwr_v.boost_output_enable;
      cfg_ff.system_voltage_floor <= pwr_v.system_voltage_floor;
      cfg_ff.boost_current_cap    <= pwr_v.boost_current_cap;
      cfg_ff.fast_charge_current  <= cur_v.fast_charge_current;
      cfg_ff.boost_cold_threshold <= cur_v.boost_cold_threshold;
      cfg_ff.reduced_charge_force <= cur_v.reduced_charge_force;
    end
  end

  assign scl_o     = pin_lo_ff;
  assign scl_oe_n  = scl_oe_n_ff;
  assign sda_o     = pin_lo_ff;
  assign sda_oe_n  = sda_oe_n_ff;
  assign cfg       = cfg_ff;
  assign host_mode = host_mode_ff;
  assign wdt_kick  = wdt_kick_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  addr_ack_a: assert property (byte_end && state_ff == ST_ADDR &&
    shift_ff[7:1] == DEV_ADDR |=> !sda_oe_n_ff ##1 !sda_oe_n_ff)
    else $error("own address not acknowledged");
  addr_miss_a: assert property (byte_end && state_ff == ST_ADDR &&
    shift_ff[7:1] != DEV_ADDR |=> state_ff == ST_IDLE && sda_oe_n_ff)
    else $error("foreign address answered");
  bad_index_a: assert property (byte_end && state_ff == ST_INDEX &&
    shift_ff > IDX_LAST |=> state_ff == ST_IDLE && sda_oe_n_ff)
    else $error("undefined index not refused");
  ro_write_a: assert property (wr_byte && idx_ff >= 8'(NUM_RW)
    |=> $stable(regs_ff))
    else $error("read-only write changed storage");
  rw_write_a: assert property (wr_byte && idx_ff == IDX_PRECHG
    |=> regs_ff[IDX_PRECHG[2:0]] == $past(shift_ff))
    else $error("writable register not updated");
  in_src_rst_a: assert property ($rose(rst_n) |->
    regs_ff[IDX_IN_SRC[2:0]] == {IN_SRC_RST_HI, $past(cap_def)})
    else $error("input source reset value wrong");
  cfg_rst_a: assert property ($rose(rst_n) |->
    regs_ff[IDX_PWR_CFG[2:0]] == PWR_CFG_RST &&
    regs_ff[IDX_CHG_CUR[2:0]] == CHG_CUR_RST)
    else $error("config reset value wrong");
  soft_reset_a: assert property (soft_rst |=>
    regs_ff[IDX_CHG_CUR[2:0]] == CHG_CUR_RST && host_mode_ff)
    else $error("soft reset failed or left host mode");
  host_mode_a: assert property (wr_byte |=> host_mode_ff)
    else $error("write did not enter host mode");
  wdt_pulse_a: assert property (wr_byte && idx_ff == IDX_PWR_CFG &&
    wr_pwr.wdt_kick |=> wdt_kick_ff ##1 !wdt_kick_ff)
    else $error("watchdog restart pulse wrong");
  boost_prio_a: assert property (cfg_ff.boost_output_enable |->
    !cfg_ff.charge_enable)
    else $error("charging while boost enabled");
  cap_min_a: assert property (##1 cfg_ff.input_current_cap <=
    $past(current_cap_pin))
    else $error("applied cap above pin setting");
  auto_inc_a: assert property (ack_end && state_ff == ST_WRITE &&
    idx_ff < IDX_AUTO_END |=> idx_ff == $past(idx_ff) + 8'h01)
    else $error("index did not advance");
  reserved_a: assert property (!regs_ff[IDX_CHG_CUR[2:0]][7])
    else $error("reserved bit set");

  read_burst_c: cover property (ack_end && state_ff == ST_READ);
  write_burst_c: cover property (wr_byte ##[1:400] wr_byte);
  soft_rst_c: cover property (soft_rst);
  bad_index_c: cover property (byte_end && state_ff == ST_INDEX &&
    shift_ff > IDX_LAST);

endmodule // chg_regbank

// ---- test_charger_config_register_bank.sv ----
// Self-checking bench for the charger configuration register bank
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  tests_run++; \
  if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
    miscompares++; \
  end
module test_charger_config_register_bank;
  import chg_pkg::*;
  localparam int LIMIT = 40000;
  logic       mclk, rst_n, source_select_pin, otg_pin;
  logic [2:0] current_cap_pin;
  chg_stat_t  status_i;
  chg_cfg_t   cfg;
  logic       host_mode, wdt_kick, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic       scl_w, sda_w, scl_drv, sda_drv, rsp_v;
  logic [8:0] rsp_d, exp_w;
  logic [8:0] exp_q[$];
  int         miscompares = 0, tests_run = 0, cyc = 0, kicks = 0;

  // Open-drain lines: low wins, otherwise pulled up
  assign scl_w = scl_drv & (scl_oe_n | scl_o);
  assign sda_w = sda_drv & (sda_oe_n | sda_o);

  chg_regbank dut (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .source_select_pin(source_select_pin),
    .otg_pin(otg_pin), .current_cap_pin(current_cap_pin),
    .status_i(status_i), .cfg(cfg), .host_mode(host_mode),
    .wdt_kick(wdt_kick)
  );

  chg_host_model host (
    .mclk(mclk), .sda_line(sda_w), .scl_drv(scl_drv),
    .sda_drv(sda_drv), .rsp_v(rsp_v), .rsp_d(rsp_d)
  );

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (wdt_kick === 1'b1) kicks++;
    if (cyc == LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end

  always @(posedge mclk) begin
    if (rsp_v === 1'b1) begin
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 9'bx;
      `CHK("bus byte", exp_w, rsp_d)
    end
  end

  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0 && exp_q.size() == 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic xbyte(input logic [7:0] d, input logic ack_in,
                       input logic [8:0] e);
    exp_q.push_back(e);
    host.byte_io(d, ack_in);
  endtask

  task automatic head(input logic [7:0] idx, input logic idx_nack);
    host.start();
    xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, {1'b0, DEV_ADDR_DEF, 1'b0});
    xbyte(idx, 1'b1, {idx_nack, idx});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
    head(idx, 1'b0);
    foreach (d[i]) xbyte(d[i], 1'b1, {1'b0, d[i]});
    host.stop();
  endtask

  // Last byte of a burst is refused by the master to end it
  task automatic rd(input logic [7:0] idx, input logic [7:0] e[$]);
    head(idx, 1'b0);
    host.start();
    xbyte({DEV_ADDR_DEF, 1'b1}, 1'b1, {1'b0, DEV_ADDR_DEF, 1'b1});
    foreach (e[i]) xbyte(8'hff, i == e.size() - 1, {i == e.size() - 1, e[i]});
    host.stop();
  endtask

  function automatic chg_cfg_t exp_cfg(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic [7:0] c);
    chg_cfg_t e;
    e.input_hiz_enable = a[7];
    e.input_voltage_floor = a[6:3];
    e.input_current_cap = (a[2:0] < current_cap_pin) ? a[2:0] : current_cap_pin;
    e.boost_output_enable = b[5];
    e.charge_enable = b[4] & ~b[5];
    e.system_voltage_floor = b[3:1];
    e.boost_current_cap = b[0];
    e.fast_charge_current = c[6:2];
    e.boost_cold_threshold = c[1];
    e.reduced_charge_force = c[0];
    return e;
  endfunction

  initial begin
    logic [7:0] a, b, c;
    logic [7:0] v[$];
    void'($urandom(32'h5d43));
    rst_n = 1'b0;
    source_select_pin = 1'b0;
    otg_pin = 1'b0;
    current_cap_pin = 3'($urandom);
    status_i = 24'($urandom);
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    rd(IDX_IN_SRC, '{8'h37, 8'h1b, 8'h60});
    `CHK("cfg", exp_cfg(8'h37, 8'h1b, 8'h60), cfg)
    `CHK("host_mode", 1'b0, host_mode)
    host.start();
    xbyte({7'h6a, 1'b0}, 1'b1, {1'b1, 7'h6a, 1'b0});
    host.stop();
    for (int k = 0; k < 4; k++) begin
      a = 8'($urandom);
      b = 8'($urandom) & 8'h3f;
      c = 8'($urandom);
      current_cap_pin = 3'($urandom);
      wr(IDX_IN_SRC, '{a, b, c});
      rd(IDX_IN_SRC, '{a, b, c & 8'h7f});
      `CHK("cfg", exp_cfg(a, b, c), cfg)
      `CHK("host_mode", 1'b1, host_mode)
    end
    // burst past the writable range, read-only untouched
    repeat (5) v.push_back(8'($urandom));
    v.push_back(8'h5a);
    wr(IDX_PRECHG, v);
    v[5] = status_i.stat_08;
    v.push_back(status_i.stat_08);
    rd(IDX_PRECHG, v);
    rd(IDX_STAT1, '{status_i.stat_09});
    rd(IDX_LAST, '{status_i.stat_0a});
    // undefined index refused, bus usable again
    head(8'h0b, 1'b1);
    host.stop();
    kicks = 0;
    for (int k = 0; k < 2; k++) begin
      host.space_kick();
      wr(IDX_PWR_CFG, '{8'h5b});
    end
    repeat (3) @(negedge mclk);
    `CHK("kicks", 2, kicks)
    rd(IDX_PWR_CFG, '{8'h1b});
    source_select_pin = 1'b1;
    for (int k = 0; k < 2; k++) begin
      otg_pin = k[0];
      wr(IDX_PWR_CFG, '{8'h80});
      rd(IDX_IN_SRC, '{k[0] ? 8'h32 : 8'h30, 8'h1b, 8'h60});
      `CHK("host_mode", 1'b1, host_mode)
    end
    rd(IDX_PRECHG, '{8'h11});
    wrap_up();
  end
endmodule // test_charger_config_register_bank
